// ==== sbp_pkg.sv ====
package sbp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register word addresses (byte offsets, one 32-bit word each)
    localparam logic [4:0] SBP_OFS_DIR = 5'h00;
    localparam logic [4:0] SBP_OFS_OUT = 5'h04;
    localparam logic [4:0] SBP_OFS_LVL = 5'h08;
    localparam logic [4:0] SBP_OFS_FUNC = 5'h0c;
    localparam logic [4:0] SBP_OFS_MUXST = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // widths and reset values
    localparam int SBP_NPIN = 6;
    localparam logic [5:0] SBP_DIR_RST = 6'h00;
    localparam logic [5:0] SBP_OUT_RST = 6'h00;
    localparam logic [9:0] SBP_FUNC_RST = 10'h000;

    ////////////////////////////////////////////////////////////////////////////
    // function control register field positions
    localparam int SBP_F_PIN_SEL = 0;
    localparam int SBP_F_SINGLE_ADDRESS_ENABLE_CH0 = 1;
    localparam int SBP_F_SINGLE_ADDRESS_ENABLE_CH1 = 2;
    localparam int SBP_F_TRANSFER_END_ENABLE_CH0 = 3;
    localparam int SBP_F_TRANSFER_END_ENABLE_CH1 = 4;
    localparam int SBP_F_AMS0 = 5;
    localparam int SBP_F_AMS1 = 6;
    localparam int SBP_F_ETE0 = 7;
    localparam int SBP_F_ETE1 = 8;
    localparam int SBP_F_EXTERNAL_BUS_EXPAND_ENABLE = 9;

    ////////////////////////////////////////////////////////////////////////////
    // pin owner codes
    typedef enum logic [1:0] {
        SBP_OWN_GPIO = 2'b00,
        SBP_OWN_INT = 2'b01,
        SBP_OWN_EXT = 2'b10
    } sbp_owner_t;

endpackage : sbp_pkg

// ==== sbp_sync.sv ====
module sbp_sync
    import sbp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous levels in, synchronised levels out
    input wire logic [5:0] async_i,
    output logic [5:0] sync_o
);

    logic [5:0] meta_q;
    logic [5:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 6'h00;
            sync_q <= 6'h00;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule : sbp_sync

// ==== sbp_pin_mux.sv ====
module sbp_pin_mux
    import sbp_pkg::*;
(
    // one strobe pin
    input wire logic external_bus_expand_enable_i,
    input wire logic ext_sel_i,
    input wire logic int_sel_i,
    input wire logic pin_sel_i,
    input wire logic ext_strobe_i,
    input wire logic int_strobe_i,
    input wire logic gpio_dir_i,
    input wire logic gpio_out_i,
    // resolved drive
    output sbp_owner_t owner_o,
    output logic pad_o,
    output logic pad_oe_o
);

    // external strobe first, then internal, else gpio
    always_comb begin
        if (external_bus_expand_enable_i && ext_sel_i) begin
            owner_o = SBP_OWN_EXT;
            pad_o = ext_strobe_i;
            pad_oe_o = 1'b1;
        end else if (int_sel_i && pin_sel_i) begin
            owner_o = SBP_OWN_INT;
            pad_o = int_strobe_i;
            pad_oe_o = 1'b1;
        end else begin
            owner_o = SBP_OWN_GPIO;
            pad_o = gpio_out_i;
            pad_oe_o = gpio_dir_i;
        end
    end

endmodule : sbp_pin_mux

// ==== sbp_port.sv ====
// Operation
// - a gpio pin is driven while its direction bit is 1 and is an input while it is 0.
// - the direction register is write-only and a read of it returns zero.
// - bits 7 and 6 of the direction and output registers read 0 and ignore writes.
// - the output register holds six read/write bits reset to 0 that drive only gpio pins.
// - a level read returns the output bit where direction is 1 and the pin where it is 0.
// - the level register is read-only and writes to it do nothing.
// - level bits 7 and 6 are reserved and bits 5 to 0 follow the pins where direction is 0.
// - in expanded modes pin 5 gives external ack 1, else internal ack 1, else gpio.
// - pin 4 follows the same order as pin 5 using channel 0.
// - in expanded modes pin 3 gives external end 1, else internal end 1, else gpio.
// - pin 2 follows the same order as pin 3 using channel 0.
// - with the expand enable at 0 the external selects are ignored.
// - pin 1 is gpio, feeds internal request 1 when selected and always external request 1.
// - level bits 5 to 0 map one to one onto pins 5 to 0.
// - pin 0 is gpio, feeds internal request 0 when selected and always external request 0.
module sbp_port
    import sbp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // port pins
    input wire logic [5:0] pad_i,
    output logic [5:0] pad_o,
    output logic [5:0] pad_oe_o,
    // on-chip dma strobes
    input wire logic int_dma_ack_0_i,
    input wire logic int_dma_ack_1_i,
    input wire logic int_transfer_end_0_i,
    input wire logic int_transfer_end_1_i,
    // external-bus dma strobes
    input wire logic ext_dma_ack_0_i,
    input wire logic ext_dma_ack_1_i,
    input wire logic ext_transfer_end_0_i,
    input wire logic ext_transfer_end_1_i,
    // requests toward the dma controllers, active low as on the pins
    output logic int_dma_request_0_n_o,
    output logic int_dma_request_1_n_o,
    output logic ext_dma_request_0_n_o,
    output logic ext_dma_request_1_n_o
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    localparam logic [4:0] SBP_ADR_DIR = SBP_OFS_DIR;
    localparam logic [4:0] SBP_ADR_OUT = SBP_OFS_OUT;
    localparam logic [4:0] SBP_ADR_LVL = SBP_OFS_LVL;
    localparam logic [4:0] SBP_ADR_FUNC = SBP_OFS_FUNC;
    localparam logic [4:0] SBP_ADR_MUXST = SBP_OFS_MUXST;

    function automatic logic hit(input logic [4:0] adr, input logic [4:0] ofs);
        hit = (adr[4:2] == ofs[4:2]);
    endfunction : hit

    logic req;
    logic wr_en;
    logic mapped;
    logic ack_q;
    logic err_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    logic [5:0] dir_q;
    logic [5:0] out_q;
    logic [9:0] func_q;
    logic [5:0] pin_sync;
    logic [5:0] level;
    sbp_owner_t owner [2:5];
    logic [11:0] mux_state;

    // the bus master holds its request until ack, so req is masked while ack or err is up
    assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign mapped = hit(wb_adr_i, SBP_ADR_DIR) || hit(wb_adr_i, SBP_ADR_OUT)
                 || hit(wb_adr_i, SBP_ADR_LVL) || hit(wb_adr_i, SBP_ADR_FUNC)
                 || hit(wb_adr_i, SBP_ADR_MUXST);
    assign wr_en = req && wb_we_i && mapped && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////////
    // handshake: one wait state, ack or err for exactly one cycle

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req && mapped;
            err_q <= req && !mapped;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    ////////////////////////////////////////////////////////////////////////////
    // direction register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= SBP_DIR_RST;
        end else if (wr_en && hit(wb_adr_i, SBP_ADR_DIR)) begin
            dir_q <= wb_dat_i[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= SBP_OUT_RST;
        end else if (wr_en && hit(wb_adr_i, SBP_ADR_OUT)) begin
            out_q <= wb_dat_i[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // function control register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            func_q <= SBP_FUNC_RST;
        end else if (wr_en && hit(wb_adr_i, SBP_ADR_FUNC)) begin
            if (wb_sel_i[1]) begin
                func_q <= wb_dat_i[9:0];
            end else begin
                func_q <= {func_q[9:8], wb_dat_i[7:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin sampling

    sbp_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(pad_i),
        .sync_o(pin_sync)
    );

    // driven bits read the latch, not the pad, so a loaded pin reads true
    assign level = (dir_q & out_q) | (~dir_q & pin_sync);

    ////////////////////////////////////////////////////////////////////////////
    // strobe pins 5 to 2

    localparam int SBP_EXT_IDX [2:5] = '{SBP_F_ETE0, SBP_F_ETE1,
                                         SBP_F_AMS0, SBP_F_AMS1};
    localparam int SBP_INT_IDX [2:5] = '{SBP_F_TRANSFER_END_ENABLE_CH0, SBP_F_TRANSFER_END_ENABLE_CH1,
                                         SBP_F_SINGLE_ADDRESS_ENABLE_CH0, SBP_F_SINGLE_ADDRESS_ENABLE_CH1};
    logic [5:2] ext_strobe;
    logic [5:2] int_strobe;

    assign ext_strobe = {ext_dma_ack_1_i, ext_dma_ack_0_i,
                         ext_transfer_end_1_i, ext_transfer_end_0_i};
    assign int_strobe = {int_dma_ack_1_i, int_dma_ack_0_i,
                         int_transfer_end_1_i, int_transfer_end_0_i};

    genvar gi;
    generate
        for (gi = 2; gi <= 5; gi++) begin : g_strobe
            sbp_pin_mux u_mux (
                .external_bus_expand_enable_i(func_q[SBP_F_EXTERNAL_BUS_EXPAND_ENABLE]),
                .ext_sel_i(func_q[SBP_EXT_IDX[gi]]),
                .int_sel_i(func_q[SBP_INT_IDX[gi]]),
                .pin_sel_i(func_q[SBP_F_PIN_SEL]),
                .ext_strobe_i(ext_strobe[gi]),
                .int_strobe_i(int_strobe[gi]),
                .gpio_dir_i(dir_q[gi]),
                .gpio_out_i(out_q[gi]),
                .owner_o(owner[gi]),
                .pad_o(pad_o[gi]),
                .pad_oe_o(pad_oe_o[gi])
            );
            assign mux_state[2*gi-4 +: 2] = owner[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // request pins 1 and 0: gpio only, also fed to the dma controllers

    assign pad_o[1:0] = out_q[1:0];
    assign pad_oe_o[1:0] = dir_q[1:0];

    // unselected internal request idles high (inactive)
    assign int_dma_request_1_n_o = func_q[SBP_F_PIN_SEL] ? pin_sync[1]
                                                         : 1'b1;
    assign int_dma_request_0_n_o = func_q[SBP_F_PIN_SEL] ? pin_sync[0]
                                                         : 1'b1;
    assign ext_dma_request_1_n_o = pin_sync[1];
    assign ext_dma_request_0_n_o = pin_sync[0];
    assign mux_state[11:8] = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered with the ack

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(wb_adr_i, SBP_ADR_OUT)) begin
            rdata_d = {26'h0, out_q};
        end else if (hit(wb_adr_i, SBP_ADR_LVL)) begin
            rdata_d = {26'h0, level};
        end else if (hit(wb_adr_i, SBP_ADR_FUNC)) begin
            rdata_d = {22'h0, func_q};
        end else if (hit(wb_adr_i, SBP_ADR_MUXST)) begin
            rdata_d = {20'h0, mux_state};
        end
        // direction reads fall through to zero
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdata_q <= rdata_d;
        end
    end

    assign wb_dat_o = rdata_q;

    // writes to the level and status words are acked and dropped

endmodule : sbp_port

// ==== sbp_port_monitor.sv ====
module sbp_port_monitor (
    // watched port signals
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [5:0] pad_i,
    input wire logic [5:0] pad_o,
    input wire logic [5:0] pad_oe_o,
    input wire logic ext_dma_request_0_n_o,
    input wire logic ext_dma_request_1_n_o,
    input wire logic int_dma_request_0_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_read(logic [2:0] a);
        s_take ##0 (!wb_we_i && wb_adr_i[4:2] == a);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_bus_answer: assert property (s_take |=> wb_ack_o || wb_err_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_dir_unread: assert property (s_read(3'h0) |=> wb_dat_o == 32'h0)
        else $error("direction read not zero");
    a_out_reserved: assert property (
        s_read(3'h1) |=> wb_dat_o[31:6] == 26'h0)
        else $error("output reserved bits not zero");
    // pin enables and gpio pins 1 and 0 move only at a write edge, never on their own
    a_oe_hold: assert property (
        !$past(rst_i) && !(wb_ack_o && wb_we_i) |-> $stable(pad_oe_o))
        else $error("enable changed without write");
    a_low_pins_hold: assert property (
        !$past(rst_i) && !(wb_ack_o && wb_we_i) |-> $stable(pad_o[1:0]))
        else $error("gpio pin changed without write");
    a_req_sync: assert property (
        !$past(rst_i) && !$past(rst_i, 2)
        |-> ext_dma_request_1_n_o == $past(pad_i[1], 2))
        else $error("request not pin level two edges back");
    a_req_gate: assert property (
        !int_dma_request_0_n_o |-> !ext_dma_request_0_n_o)
        else $error("internal request without pin");
endmodule : sbp_port_monitor

// ==== sbp_pins_model.sv ====
module sbp_pins_model (
    // clock
    input wire logic clk_i,
    // device drive and far-side level
    input wire logic [5:0] drive_i,
    input wire logic [5:0] drive_en_i,
    input wire logic [5:0] far_lvl_i,
    // resolved pins and dma strobes
    output logic [5:0] pad_lvl_o,
    output logic [7:0] strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q = 8'h00;
    // device drive wins; contention is not modelled
    assign pad_lvl_o = (drive_en_i & drive_i) | (~drive_en_i & far_lvl_i);
    always_ff @(posedge clk_i) begin
        cnt_q <= cnt_q + 8'h01;
    end
    // scrambled, but strobe_o bits n and n+4 are always equal, so those two sources never differ
    assign strobe_o = cnt_q ^ {cnt_q[3:0], cnt_q[7:4]};
endmodule : sbp_pins_model

// ==== sbp_port_tb.sv ====
module sbp_port_tb;
    import sbp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic rerr;
    logic [31:0] dat_o;
    logic ack_o;
    logic err_o;
    logic [5:0] pad_i;
    logic [5:0] pad_o;
    logic [5:0] pad_oe_o;
    logic [5:0] far_lvl = 6'h2a;
    logic [7:0] st;
    wire [3:0] rq;
    int n_fail = 0;
    int compares = 0;
    always #20 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    sbp_port sbp_port_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
        .wb_err_o(err_o), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
        .int_dma_ack_0_i(st[2]), .int_dma_ack_1_i(st[3]),
        .int_transfer_end_0_i(st[0]), .int_transfer_end_1_i(st[1]),
        .ext_dma_ack_0_i(st[6]), .ext_dma_ack_1_i(st[7]),
        .ext_transfer_end_0_i(st[4]), .ext_transfer_end_1_i(st[5]),
        .int_dma_request_0_n_o(rq[0]), .int_dma_request_1_n_o(rq[1]),
        .ext_dma_request_0_n_o(rq[2]), .ext_dma_request_1_n_o(rq[3]));
    sbp_pins_model sbp_pins_model_inst (.clk_i(clk_i), .drive_i(pad_o),
        .drive_en_i(pad_oe_o), .far_lvl_i(far_lvl), .pad_lvl_o(pad_i),
        .strobe_o(st));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // holds the request until ack or err is sampled, then one idle cycle
    task automatic xfer(input logic w, input logic [4:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1 && err_o !== 1'b1) begin
            n_fail++;
            stop_test();
        end
        rdat = dat_o;
        rerr = err_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic rd(input logic [4:0] a, input logic [31:0] e, string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, rdat, e);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [9:0] ft [5];
        int ib [4];
        int eb [4];
        logic e;
        logic i;
        logic eo;
        logic ev;
        logic [5:0] dir_v;
        logic [5:0] out_v;
        logic [7:0] ms;
        ft = '{10'h1ff, 10'h3ff, 10'h21e, 10'h2a7, 10'h000};
        ms = 8'h00;
        ib = '{SBP_F_TRANSFER_END_ENABLE_CH0, SBP_F_TRANSFER_END_ENABLE_CH1, SBP_F_SINGLE_ADDRESS_ENABLE_CH0, SBP_F_SINGLE_ADDRESS_ENABLE_CH1};
        eb = '{SBP_F_ETE0, SBP_F_ETE1, SBP_F_AMS0, SBP_F_AMS1};
        dir_v = 6'h14;
        out_v = 6'h2b;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(5'h04, 32'h0, "out reset");
        chk("oe reset", pad_oe_o, 6'h00);
        $display("test reset finished");
        xfer(1'b1, 5'h04, 32'hffff_ffeb);
        rd(5'h04, 32'h2b, "out");
        xfer(1'b1, 5'h00, 32'hff);
        rd(5'h00, 32'h0, "dir read");
        chk("oe out", pad_oe_o, 6'h3f);
        chk("pad out", pad_o, 6'h2b);
        xfer(1'b1, 5'h08, 32'h3f);
        rd(5'h04, 32'h2b, "out kept");
        rd(5'h08, 32'h2b, "lvl out");
        xfer(1'b0, 5'h14, 32'h0);
        chk("unmapped err", rerr, 1'b1);
        $display("test registers finished");
        xfer(1'b1, 5'h00, 32'h0);
        repeat (3) @(posedge clk_i);
        rd(5'h08, 32'h2a, "lvl pins");
        chk("ext req", rq[3:2], 2'b10);
        chk("int req idle", rq[1:0], 2'b11);
        xfer(1'b1, 5'h0c, 32'h1);
        chk("int req sel", rq[1:0], 2'b10);
        $display("test requests finished");
        xfer(1'b1, 5'h00, {26'h0, dir_v});
        foreach (ft[k]) begin
            xfer(1'b1, 5'h0c, {22'h0, ft[k]});
            repeat (2) begin
                @(negedge clk_i);
                for (int p = 2; p < 6; p++) begin
                    e = ft[k][SBP_F_EXTERNAL_BUS_EXPAND_ENABLE] && ft[k][eb[p-2]];
                    i = ft[k][SBP_F_PIN_SEL] && ft[k][ib[p-2]];
                    eo = e || i || dir_v[p];
                    ev = e ? st[p+2] : (i ? st[p-2] : out_v[p]);
                    ms[2*p-4 +: 2] = e ? 2'b10 : (i ? 2'b01 : 2'b00);
                    chk("pin oe", pad_oe_o[p], eo);
                    chk("pin drive", pad_o[p] & eo, ev & eo);
                end
            end
            // requests must start right after a rising edge
            @(posedge clk_i);
            rd(5'h10, {24'h0, ms}, "mux state");
        end
        $display("test mux finished");
        stop_test();
    end
endmodule : sbp_port_tb

bind sbp_port sbp_port_monitor sbp_port_monitor_inst (.*);
